// ===== rtl/ici_top.sv
`timescale 1ns/1ns

// ============================================================
// Operation
// - digital input polarity selectable per input
// - one action per input, one or all channels
// - safety stop until command zero or reversed
// - emergency stop latched until reset or release
// - deadman stops only while input asserted
// - invert reverses channel command on o_cmd, not routed o_acmd
// - forward limit holds until reverse command
// - reverse limit holds until forward command
// - run script starts user script, no channel
// - load home loads channel position counter
// - analog input disabled, absolute or relative
// - disabled analog input captures zero
// - absolute capture gives real input voltage
// - relative capture ratioed so 5V reads 5.0V
// - analog min/max thresholds trigger actions
// - scale to -1000..+1000 via min/center/max
// - center at minimum gives positive output only
// - deadband 0..50 percent zeroes near center
// - deadband rescales, full input gives full output
// - linear, three exponential, three logarithmic curves
// - linear curve passes value unchanged
// - processed value routed as command or feedback
module ici_top
  import ici_pkg::*;
#(
  parameter int NDIN = 4,
  parameter int NAIN = 2,
  parameter int NCH = 2,
  parameter logic [12:0] ABS_FS_MV = ICI_ABS_FS
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // digital inputs and their setup
  input wire logic [NDIN-1:0] i_din,
  input wire logic [NDIN-1:0] i_din_act_low,
  input wire ici_act_cfg_t [NDIN-1:0] i_din_cfg,
  // analog samples and setup
  input wire logic [NAIN-1:0][ICI_ADC_W-1:0] i_adc,
  input wire logic [ICI_ADC_W-1:0] i_adc_5v,
  input wire logic i_adc_valid,
  input wire ici_ain_cfg_t [NAIN-1:0] i_ain_cfg,
  // motor commands in, emergency release
  input wire logic [NCH-1:0][ICI_CMD_W-1:0] i_cmd,
  input wire logic i_estop_release,
  // motor side results
  output logic [NCH-1:0][ICI_CMD_W-1:0] o_cmd,
  output logic [NCH-1:0] o_halt,
  output logic o_estop,
  output logic o_script_start,
  output logic [NCH-1:0] o_home_load,
  // processed analog values
  output logic [NAIN-1:0][ICI_CMD_W-1:0] o_ain_val,
  output logic [NCH-1:0][ICI_CMD_W-1:0] o_acmd,
  output logic [NCH-1:0] o_acmd_vld,
  output logic [NCH-1:0][ICI_CMD_W-1:0] o_afbk,
  output logic [NCH-1:0] o_afbk_vld
);

  localparam int NSRC = NDIN + 2 * NAIN;

  // ==========================================================
  // elaboration checks: channel field and mask are 2 and 3 bits
  if (NCH < 1 || NCH > 3) begin : g_bad_nch
    $error("NCH must be 1 to 3");
  end
  if (NDIN < 1 || NAIN < 1) begin : g_bad_in
    $error("need at least one input of each kind");
  end

  // true when a source's action matches and targets channel ch
  function automatic logic ici_sel(input ici_act_cfg_t c,
                                   input ici_act_t a,
                                   input int ch);
    return c.act == a && (c.chan == 2'h0 || int'(c.chan) == ch + 1);
  endfunction

  // ==========================================================
  // action sources: digital pins then analog lo/hi detectors
  logic [NSRC-1:0] src_lvl, src_prev_r, src_rise;
  ici_act_cfg_t [NSRC-1:0] src_cfg;
  logic [NAIN-1:0] lo_hit_r, hi_hit_r, lo_nxt, hi_nxt;

  assign src_lvl[NDIN-1:0] = i_din ^ i_din_act_low;
  assign src_cfg[NDIN-1:0] = i_din_cfg;
  assign src_rise = src_lvl & ~src_prev_r;

  for (genvar g = 0; g < NAIN; g++) begin : g_src
    assign src_lvl[NDIN+2*g] = lo_hit_r[g];
    assign src_lvl[NDIN+2*g+1] = hi_hit_r[g];
    assign src_cfg[NDIN+2*g] = i_ain_cfg[g].lo_act;
    assign src_cfg[NDIN+2*g+1] = i_ain_cfg[g].hi_act;
  end

  // ==========================================================
  // action decode; the no-action code matches nothing
  logic [NCH-1:0] h_ss, h_dead, h_inv, h_fl, h_rl, h_home;
  logic h_es, h_scr;

  always_comb begin
    h_ss = '0;
    h_dead = '0;
    h_inv = '0;
    h_fl = '0;
    h_rl = '0;
    h_home = '0;
    h_es = 1'b0;
    h_scr = 1'b0;
    for (int s = 0; s < NSRC; s++) begin
      h_es |= src_lvl[s] && src_cfg[s].act == ICI_ACT_ESTOP;
      h_scr |= src_rise[s] && src_cfg[s].act == ICI_ACT_SCRIPT;
      for (int c = 0; c < NCH; c++) begin
        h_ss[c] |= src_lvl[s] && ici_sel(src_cfg[s], ICI_ACT_SSTOP, c);
        h_dead[c] |= src_lvl[s] && ici_sel(src_cfg[s], ICI_ACT_DEAD, c);
        h_inv[c] |= src_lvl[s] && ici_sel(src_cfg[s], ICI_ACT_INV, c);
        h_fl[c] |= src_lvl[s] && ici_sel(src_cfg[s], ICI_ACT_FLIM, c);
        h_rl[c] |= src_lvl[s] && ici_sel(src_cfg[s], ICI_ACT_RLIM, c);
        h_home[c] |= src_rise[s]
                     && ici_sel(src_cfg[s], ICI_ACT_HOME, c);
      end
    end
  end

  // ==========================================================
  // per channel stop latches; a new trigger beats any release
  logic [NCH-1:0] sstop_r, sstop_nxt, sdir_r, sdir_nxt;
  logic [NCH-1:0] flim_r, flim_nxt, rlim_r, rlim_nxt, halt_nxt;
  logic [NCH-1:0][ICI_CMD_W-1:0] cmd_nxt, cmd_sat;
  logic estop_r, estop_nxt;

  assign estop_nxt = h_es | (estop_r & ~i_estop_release);

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic signed [10:0] cin, cs;
    logic neg, pos;
    // clamp the incoming command to full scale first
    assign cin = $signed(i_cmd[c]);
    assign cs = (cin > 11'sh3E8) ? 11'sh3E8 :
                (cin < -11'sh3E8) ? -11'sh3E8 : cin;
    assign cmd_sat[c] = cs;
    assign neg = cs[10];
    assign pos = !neg && cs != '0;
    assign sstop_nxt[c] = h_ss[c] | (sstop_r[c]
                          & ~(cs == '0 | neg != sdir_r[c]));
    assign sdir_nxt[c] = (h_ss[c] & ~sstop_r[c]) ? neg : sdir_r[c];
    assign flim_nxt[c] = h_fl[c] | (flim_r[c] & ~neg);
    assign rlim_nxt[c] = h_rl[c] | (rlim_r[c] & ~pos);
    assign halt_nxt[c] = estop_nxt | sstop_nxt[c] | flim_nxt[c]
                         | rlim_nxt[c] | h_dead[c];
    assign cmd_nxt[c] = halt_nxt[c] ? '0 :
                        h_inv[c] ? 11'(-cs) : cs;
  end

  // safety, limit and emergency stop state registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      sstop_r <= '0;
      sdir_r <= '0;
      flim_r <= '0;
      rlim_r <= '0;
      estop_r <= 1'b0;
    end else begin
      sstop_r <= sstop_nxt;
      sdir_r <= sdir_nxt;
      flim_r <= flim_nxt;
      rlim_r <= rlim_nxt;
      estop_r <= estop_nxt;
    end
  end

  // outputs toward the motor channels
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_cmd <= '0;
      o_halt <= '0;
      o_script_start <= 1'b0;
      o_home_load <= '0;
      src_prev_r <= '0;
    end else begin
      o_cmd <= cmd_nxt;
      o_halt <= halt_nxt;
      o_script_start <= h_scr;
      o_home_load <= h_home;
      src_prev_r <= src_lvl;
    end
  end

  assign o_estop = estop_r;

  // ==========================================================
  // analog capture; relative mode divides by the measured 5V
  logic [NAIN-1:0][ICI_MV_W-1:0] cap_r, cap_nxt;
  logic [NAIN-1:0][ICI_CMD_W-1:0] sc_val;
  logic [NAIN-1:0] sc_vld, cv_vld;
  logic cap_vld_r;

  for (genvar g = 0; g < NAIN; g++) begin : g_ain
    logic [24:0] abs_p, rel_p, rel_q;
    logic [12:0] rel_mv;
    assign abs_p = i_adc[g] * ABS_FS_MV;
    assign rel_p = i_adc[g] * ICI_REL_MV;
    assign rel_q = (i_adc_5v == '0) ? '1 : rel_p / i_adc_5v;
    assign rel_mv = (rel_q > 25'(ICI_MV_MAX)) ? ICI_MV_MAX
                    : rel_q[12:0];
    assign cap_nxt[g] = (i_ain_cfg[g].mode == ICI_CAP_ABS) ?
                        abs_p[24:12] :
                        (i_ain_cfg[g].mode == ICI_CAP_REL) ? rel_mv
                        : '0;
    // threshold detectors watch the held capture
    assign lo_nxt[g] = i_ain_cfg[g].lo_en
                       && cap_r[g] < i_ain_cfg[g].lo_mv;
    assign hi_nxt[g] = i_ain_cfg[g].hi_en
                       && cap_r[g] > i_ain_cfg[g].hi_mv;

    ici_scale u_scale (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_vld(cap_vld_r),
      .i_x(cap_r[g]),
      .i_cfg(i_ain_cfg[g]),
      .o_vld(sc_vld[g]),
      .o_val(sc_val[g])
    );

    ici_curve u_curve (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_vld(sc_vld[g]),
      .i_val(sc_val[g]),
      .i_curve(i_ain_cfg[g].curve),
      .o_vld(cv_vld[g]),
      .o_val(o_ain_val[g])
    );
  end

  // capture and detection registers, in stage order
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      cap_r <= '0;
      cap_vld_r <= 1'b0;
      lo_hit_r <= '0;
      hi_hit_r <= '0;
    end else begin
      cap_vld_r <= i_adc_valid;
      if (i_adc_valid) cap_r <= cap_nxt;
      lo_hit_r <= lo_nxt;
      hi_hit_r <= hi_nxt;
    end
  end

  // ==========================================================
  // routing; the lowest numbered input wins a shared channel
  logic [NCH-1:0][ICI_CMD_W-1:0] acmd_nxt, afbk_nxt;
  logic [NCH-1:0] acv_nxt, afv_nxt;

  always_comb begin
    acmd_nxt = '0;
    afbk_nxt = '0;
    acv_nxt = '0;
    afv_nxt = '0;
    for (int c = 0; c < NCH; c++) begin
      for (int a = NAIN - 1; a >= 0; a--) begin
        if (i_ain_cfg[a].chmask[c]) begin
          if (i_ain_cfg[a].use_as == ICI_USE_CMD) begin
            acmd_nxt[c] = o_ain_val[a];
            acv_nxt[c] = 1'b1;
          end
          if (i_ain_cfg[a].use_as == ICI_USE_FBK) begin
            afbk_nxt[c] = o_ain_val[a];
            afv_nxt[c] = 1'b1;
          end
        end
      end
    end
  end

  // routed value registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_acmd <= '0;
      o_afbk <= '0;
      o_acmd_vld <= '0;
      o_afbk_vld <= '0;
    end else begin
      o_acmd <= acmd_nxt;
      o_afbk <= afbk_nxt;
      o_acmd_vld <= acv_nxt;
      o_afbk_vld <= afv_nxt;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);

  a_deadman_halt: assert property (h_dead[0] |=>
    o_halt[0] && o_cmd[0] == '0)
    else $error("deadman did not stop channel 0");
  a_estop_latch: assert property (o_estop && !i_estop_release
    |=> o_estop)
    else $error("emergency stop released early");
  a_estop_halts: assert property (o_estop |-> &o_halt)
    else $error("emergency stop left a channel running");
  a_sstop_clear: assert property (sstop_r[NCH-1] && !h_ss[NCH-1]
    && (cmd_sat[NCH-1] == '0 || cmd_sat[NCH-1][10] != sdir_r[NCH-1])
    |=> !sstop_r[NCH-1])
    else $error("safety stop not released at zero or reversal");
  a_flim_hold: assert property (flim_r[0] && !cmd_sat[0][10]
    |=> flim_r[0] && o_halt[0])
    else $error("forward limit released without reverse");
  a_rlim_hold: assert property (rlim_r[0]
    && (cmd_sat[0][10] || cmd_sat[0] == '0) |=> rlim_r[0])
    else $error("reverse limit released without forward");
  a_invert_cmd: assert property (h_inv[0] && !halt_nxt[0]
    |=> o_cmd[0] == 11'(-$signed($past(cmd_sat[0]))))
    else $error("inverted command wrong");
  a_script_pulse: assert property (o_script_start && !h_scr
    |=> !o_script_start)
    else $error("script start longer than one cycle");
  a_disabled_zero: assert property (i_adc_valid
    && i_ain_cfg[NAIN-1].mode == ICI_CAP_DIS |=> cap_r[NAIN-1] == '0)
    else $error("disabled input captured nonzero");
  a_relative_5v: assert property (i_adc_valid
    && i_ain_cfg[0].mode == ICI_CAP_REL && i_adc_5v != '0
    && i_adc[0] == i_adc_5v |=> cap_r[0] == ICI_REL_MV)
    else $error("relative capture of 5V output not 5.0V");
  a_pipe_order: assert property (i_adc_valid
    |-> ##4 cv_vld[0])
    else $error("analog pipeline latency wrong");

  c_estop: cover property (h_es ##1 o_estop ##1 i_estop_release);
  c_flim: cover property (flim_r[0] ##[1:20] !flim_r[0]);
  c_script: cover property (o_script_start);
  c_route: cover property (o_acmd_vld[0] && o_acmd[0] != '0);

endmodule // ici_top

// ===== rtl/ici_pkg.sv
package ici_pkg;

  // ==========================================================
  // widths and scale
  localparam int ICI_ADC_W = 12;
  localparam int ICI_MV_W = 13;
  localparam int ICI_CMD_W = 11;
  localparam int ICI_FULL = 1000;
  localparam int ICI_DB_MAX = 50;
  localparam int ICI_DB_STEP = 10;
  localparam int ICI_CRV_DIV = 4;
  localparam logic [12:0] ICI_REL_MV = 13'h1388;
  localparam logic [12:0] ICI_MV_MAX = 13'h1FFF;
  localparam logic [12:0] ICI_ABS_FS = 13'h1388;

  // ==========================================================
  // actions, modes, curves
  typedef enum logic [3:0] {
    ICI_ACT_NONE = 4'h0,
    ICI_ACT_SSTOP = 4'h1,
    ICI_ACT_ESTOP = 4'h2,
    ICI_ACT_DEAD = 4'h3,
    ICI_ACT_INV = 4'h4,
    ICI_ACT_FLIM = 4'h5,
    ICI_ACT_RLIM = 4'h6,
    ICI_ACT_SCRIPT = 4'h7,
    ICI_ACT_HOME = 4'h8
  } ici_act_t;

  typedef enum logic [1:0] {
    ICI_CAP_DIS = 2'h0,
    ICI_CAP_ABS = 2'h1,
    ICI_CAP_REL = 2'h2
  } ici_cap_t;

  // low bits are the strength, bit 2 selects the log family
  typedef enum logic [2:0] {
    ICI_CRV_LIN = 3'h0,
    ICI_CRV_EXPW = 3'h1,
    ICI_CRV_EXPM = 3'h2,
    ICI_CRV_EXPS = 3'h3,
    ICI_CRV_LOGW = 3'h5,
    ICI_CRV_LOGM = 3'h6,
    ICI_CRV_LOGS = 3'h7
  } ici_crv_t;

  typedef enum logic [1:0] {
    ICI_USE_NONE = 2'h0,
    ICI_USE_CMD = 2'h1,
    ICI_USE_FBK = 2'h2
  } ici_use_t;

  // ==========================================================
  // carriers; chan 0 means all channels
  typedef struct packed {
    ici_act_t act;
    logic [1:0] chan;
  } ici_act_cfg_t;

  typedef struct packed {
    ici_cap_t mode;
    logic [12:0] min_mv;
    logic [12:0] ctr_mv;
    logic [12:0] max_mv;
    logic [5:0] db_pct;
    ici_crv_t curve;
    logic lo_en;
    logic hi_en;
    logic [12:0] lo_mv;
    logic [12:0] hi_mv;
    ici_act_cfg_t lo_act;
    ici_act_cfg_t hi_act;
    ici_use_t use_as;
    logic [2:0] chmask;
  } ici_ain_cfg_t;

endpackage

// ===== rtl/ici_scale.sv
`timescale 1ns/1ns

// ============================================================
// min/center/max scaling then deadband, one register each
module ici_scale
  import ici_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // captured sample
  input wire logic i_vld,
  input wire logic [ICI_MV_W-1:0] i_x,
  input wire ici_ain_cfg_t i_cfg,
  // scaled result
  output logic o_vld,
  output logic [ICI_CMD_W-1:0] o_val
);

  logic signed [31:0] x, mn, ct, mx, sc, av, band, dbm;
  logic signed [10:0] sc_r;
  logic vld_r;
  logic [5:0] db;

  // branches are ordered so no divisor can reach zero
  assign x = 32'(i_x);
  assign mn = 32'(i_cfg.min_mv);
  assign ct = 32'(i_cfg.ctr_mv);
  assign mx = 32'(i_cfg.max_mv);
  assign sc = (x >= ct) ? ((x >= mx) ? ICI_FULL :
              ((x - ct) * ICI_FULL) / (mx - ct)) :
              (ct <= mn) ? '0 :
              (x <= mn) ? -ICI_FULL :
              -(((ct - x) * ICI_FULL) / (ct - mn));

  // deadband clamps at half scale and rescales what remains
  assign db = (i_cfg.db_pct > 6'(ICI_DB_MAX)) ? 6'(ICI_DB_MAX)
              : i_cfg.db_pct;
  assign band = 32'(db) * ICI_DB_STEP;
  assign av = sc_r[10] ? -32'(sc_r) : 32'(sc_r);
  assign dbm = (av <= band) ? '0 :
               ((av - band) * ICI_FULL) / (ICI_FULL - band);

  // two stage pipeline
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      sc_r <= '0;
      vld_r <= 1'b0;
      o_vld <= 1'b0;
      o_val <= '0;
    end else begin
      vld_r <= i_vld;
      if (i_vld) sc_r <= 11'(sc);
      o_vld <= vld_r;
      if (vld_r) o_val <= 11'(sc_r[10] ? -dbm : dbm);
    end
  end

  a_scale_range: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    vld_r |-> (sc_r <= 11'sh3E8 && sc_r >= -11'sh3E8))
    else $error("scaled value out of range");
  a_minctr_pos: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    i_vld && i_cfg.ctr_mv == i_cfg.min_mv |=> !sc_r[10])
    else $error("negative output with center at minimum");
  a_dband_zero: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    vld_r && av <= band |=> o_val == '0)
    else $error("deadband did not force zero");

endmodule // ici_scale

// ===== rtl/ici_curve.sv
`timescale 1ns/1ns

// ============================================================
// correction curve: blend of linear and a square-law shape
module ici_curve
  import ici_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // value in
  input wire logic i_vld,
  input wire logic [ICI_CMD_W-1:0] i_val,
  input wire ici_crv_t i_curve,
  // corrected value
  output logic o_vld,
  output logic [ICI_CMD_W-1:0] o_val
);

  logic signed [31:0] av, k, sq, tgt, mag;

  // strength 0 gives the plain input, so linear is exact
  assign av = i_val[10] ? -32'($signed(i_val)) : 32'($signed(i_val));
  assign k = 32'(i_curve[1:0]);
  assign sq = (av * av) / ICI_FULL;
  assign tgt = i_curve[2] ? (av + av - sq) : sq;
  assign mag = (av * (ICI_CRV_DIV - k) + tgt * k) / ICI_CRV_DIV;

  // result register
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_vld <= 1'b0;
      o_val <= '0;
    end else begin
      o_vld <= i_vld;
      if (i_vld) o_val <= 11'(i_val[10] ? -mag : mag);
    end
  end

  a_linear_pass: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    i_vld && i_curve == ICI_CRV_LIN |=> o_val == $past(i_val))
    else $error("linear curve changed the value");
  a_curve_sign: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    i_vld |=> o_val[10] == ($past(i_val[10]) && o_val != '0))
    else $error("curve flipped the sign");

endmodule // ici_curve

// ===== bench/ici_field_model.sv
`timescale 1ns/1ns

// ==========================================================
// switches and potentiometers wired to the input pins
module ici_field_model
  import ici_pkg::*;
#(
  parameter int FS_MV = 5000
) (
  // switch contacts, wiring and pot voltages in mV
  input wire logic [3:0] i_closed,
  input wire logic [3:0] i_wired_low,
  input wire logic [1:0][12:0] i_mv,
  input wire logic [12:0] i_rail_mv,
  input wire logic i_sample,
  // pin levels and converter codes
  output logic [3:0] o_din,
  output logic [1:0][11:0] o_adc,
  output logic [11:0] o_adc_5v,
  output logic o_adc_valid
);
  // converter clips at its top code rather than wrapping
  function automatic logic [11:0] conv(input logic [12:0] mv);
    int c;
    c = int'(mv) * 4096 / FS_MV;
    return (c > 4095) ? 12'hFFF : 12'(c);
  endfunction

  // switch to ground has a pull-up, switch to 5V a pull-down
  assign o_din = i_closed ^ i_wired_low;
  assign o_adc[0] = conv(i_mv[0]);
  assign o_adc[1] = conv(i_mv[1]);
  assign o_adc_5v = conv(i_rail_mv);
  assign o_adc_valid = i_sample;
endmodule // ici_field_model

// ===== bench/test_input_conditioning_actions.sv
`timescale 1ns/1ns

module test_input_conditioning_actions
  import ici_pkg::*;
;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] closed = 4'h0;
  logic [3:0] wired_low = 4'h5;
  logic [1:0][12:0] pot_mv = 26'h0;
  logic [12:0] rail_mv = 13'h12C0;
  logic sample = 1'b0;
  logic [3:0] din;
  logic [1:0][11:0] adc;
  logic [11:0] adc_5v;
  logic adc_vld;
  ici_act_cfg_t [3:0] dcfg = '0;
  ici_ain_cfg_t [1:0] acfg = '0;
  logic [1:0][10:0] cmd = {11'h0C8, 11'h12C};
  logic rel = 1'b0;
  logic [1:0][10:0] ocmd, acmd, afbk, ain;
  logic [1:0] halt, home, acmd_vld, afbk_vld;
  logic estop, script;
  int err_count = 0;
  int compares = 0;

  always #4 clk = ~clk;

  ici_field_model field (.i_closed(closed), .i_wired_low(wired_low),
    .i_mv(pot_mv), .i_rail_mv(rail_mv), .i_sample(sample), .o_din(din),
    .o_adc(adc), .o_adc_5v(adc_5v), .o_adc_valid(adc_vld));

  ici_top dut (.i_clk_sys(clk), .i_resetn(rst_n), .i_din(din),
    .i_din_act_low(wired_low), .i_din_cfg(dcfg), .i_adc(adc),
    .i_adc_5v(adc_5v), .i_adc_valid(adc_vld), .i_ain_cfg(acfg),
    .i_cmd(cmd), .i_estop_release(rel), .o_cmd(ocmd), .o_halt(halt),
    .o_estop(estop), .o_script_start(script), .o_home_load(home),
    .o_ain_val(ain), .o_acmd(acmd), .o_acmd_vld(acmd_vld), .o_afbk(afbk),
    .o_afbk_vld(afbk_vld));

  // ==========================================================
  // shared helpers; inputs move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [10:0] seen,
      input logic [10:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %0d seen %0d", what, $signed(exp),
        $signed(seen));
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one strobe, then wait out the four-stage pipe plus routing
  task automatic take();
    sample = 1'b1;
    step(1);
    sample = 1'b0;
    step(7);
  endtask

  function automatic int code(input int mv);
    return mv * 4096 / 5000;
  endfunction

  function automatic int scl(input int x, input int mn, input int ct,
      input int mx);
    if (x >= ct) return (x >= mx) ? 1000 : (x - ct) * 1000 / (mx - ct);
    if (ct <= mn) return 0;
    return (x <= mn) ? -1000 : -((ct - x) * 1000 / (ct - mn));
  endfunction

  // deadband then curve, sign handled on the magnitude
  function automatic int post(input int v, input int db, input int c);
    int a;
    int b;
    int t;
    a = (v < 0) ? -v : v;
    b = db * 10;
    a = (a <= b) ? 0 : (a - b) * 1000 / (1000 - b);
    t = a * a / 1000;
    if (c >= 4) t = 2 * a - t;
    a = (a * (4 - c % 4) + t * (c % 4)) / 4;
    return (v < 0) ? -a : a;
  endfunction

  function automatic ici_ain_cfg_t mk(input ici_cap_t m, input int mn,
      input int ct, input int mx, input int db, input ici_crv_t c);
    ici_ain_cfg_t r;
    r = '0;
    r.mode = m;
    r.min_mv = 13'(mn);
    r.ctr_mv = 13'(ct);
    r.max_mv = 13'(mx);
    r.db_pct = 6'(db);
    r.curve = c;
    return r;
  endfunction

  // ==========================================================
  // digital input scenarios
  task automatic t_dead();
    closed = 4'hF;
    step(2);
    chk("idle halt", 11'(halt), 11'h0);
    closed = 4'h0;
    dcfg[0] = '{ICI_ACT_DEAD, 2'h1};
    closed[0] = 1'b1;
    step(2);
    chk("dead halt", 11'(halt), 11'h1);
    chk("dead cmd0", ocmd[0], 11'h0);
    chk("dead cmd1", ocmd[1], 11'h0C8);
    closed[0] = 1'b0;
    step(2);
    chk("dead resume", ocmd[0], 11'h12C);
    dcfg[0] = '0;
  endtask

  task automatic t_inv();
    dcfg[1] = '{ICI_ACT_INV, 2'h0};
    closed[1] = 1'b1;
    step(2);
    chk("inv cmd0", ocmd[0], 11'(-300));
    chk("inv cmd1", ocmd[1], 11'(-200));
    closed[1] = 1'b0;
    dcfg[1] = '0;
    step(2);
  endtask

  task automatic t_sstop();
    dcfg[2] = '{ICI_ACT_SSTOP, 2'h2};
    closed[2] = 1'b1;
    step(1);
    closed[2] = 1'b0;
    step(3);
    chk("sstop held", 11'(halt), 11'h2);
    cmd[1] = 11'(-200);
    step(2);
    chk("sstop free", 11'(halt), 11'h0);
    chk("sstop cmd", ocmd[1], 11'(-200));
    cmd[1] = 11'h0C8;
    dcfg[2] = '0;
    step(2);
  endtask

  // forward limit then reverse limit, mirrored signs
  task automatic t_limits();
    int s;
    for (int i = 0; i < 2; i++) begin
      s = (i == 0) ? 1 : -1;
      cmd[0] = 11'(s * 300);
      dcfg[3] = '{(i == 0) ? ICI_ACT_FLIM : ICI_ACT_RLIM, 2'h1};
      closed[3] = 1'b1;
      step(2);
      closed[3] = 1'b0;
      cmd[0] = 11'(s * 500);
      step(3);
      chk("lim held", 11'(halt), 11'h1);
      chk("lim cmd", ocmd[0], 11'h0);
      cmd[0] = 11'(-s * 300);
      step(2);
      chk("lim free", ocmd[0], 11'(-s * 300));
    end
    cmd[0] = 11'h12C;
    dcfg[3] = '0;
    step(2);
  endtask

  task automatic t_estop();
    dcfg[0] = '{ICI_ACT_ESTOP, 2'h0};
    closed[0] = 1'b1;
    step(1);
    closed[0] = 1'b0;
    step(4);
    chk("estop latch", 11'(estop), 11'h1);
    chk("estop halt", 11'(halt), 11'h3);
    rel = 1'b1;
    step(1);
    rel = 1'b0;
    step(2);
    chk("estop free", 11'(halt), 11'h0);
    dcfg[0] = '0;
  endtask

  // level held for five cycles must give exactly one pulse
  task automatic t_pulse();
    int ns;
    int nh;
    ns = 0;
    nh = 0;
    dcfg[1] = '{ICI_ACT_SCRIPT, 2'h0};
    dcfg[2] = '{ICI_ACT_HOME, 2'h2};
    closed[2:1] = 2'h3;
    for (int i = 0; i < 5; i++) begin
      step(1);
      ns += int'(script);
      nh += int'(home[1]) + 2 * int'(home[0]);
    end
    chk("script pulses", 11'(ns), 11'h1);
    chk("home pulses", 11'(nh), 11'h1);
    closed[2:1] = 2'h0;
    dcfg = '0;
    step(2);
  endtask

  // ==========================================================
  // analog scenarios
  task automatic t_abs();
    int mvs [6] = '{1500, 2500, 4000, 4800, 1000, 800};
    int e;
    acfg[0] = mk(ICI_CAP_ABS, 1000, 2500, 4000, 0, ICI_CRV_LIN);
    acfg[0].use_as = ICI_USE_CMD;
    acfg[0].chmask = 3'h1;
    // min and center at zero so a zero capture scales to zero
    acfg[1] = mk(ICI_CAP_DIS, 0, 0, 4000, 0, ICI_CRV_LIN);
    acfg[1].use_as = ICI_USE_FBK;
    acfg[1].chmask = 3'h2;
    foreach (mvs[i]) begin
      pot_mv = {13'(mvs[i]), 13'(mvs[i])};
      take();
      e = scl(code(mvs[i]) * 5000 / 4096, 1000, 2500, 4000);
      chk("abs val", ain[0], 11'(e));
      chk("route cmd", acmd[0], 11'(e));
      chk("dis val", afbk[1], 11'h0);
      chk("route vld", 11'({afbk_vld, acmd_vld}), 11'h9);
    end
  endtask

  task automatic t_curves();
    ici_crv_t cs [7] = '{ICI_CRV_LIN, ICI_CRV_EXPW, ICI_CRV_EXPM,
      ICI_CRV_EXPS, ICI_CRV_LOGW, ICI_CRV_LOGM, ICI_CRV_LOGS};
    int v;
    foreach (cs[i]) begin
      acfg[0] = mk(ICI_CAP_ABS, 1000, 2500, 4000, 20, cs[i]);
      pot_mv[0] = 13'(i == 3 ? 4000 : 1400 + 300 * i);
      take();
      v = scl(code(int'(pot_mv[0])) * 5000 / 4096, 1000, 2500, 4000);
      v = post(v, 20, int'(cs[i]));
      chk("curve val", ain[0], 11'(v));
    end
  endtask

  task automatic t_rel();
    int c5;
    c5 = code(4800);
    acfg[0] = mk(ICI_CAP_REL, 0, 0, 8000, 0, ICI_CRV_LIN);
    acfg[1] = mk(ICI_CAP_ABS, 1000, 1000, 4000, 0, ICI_CRV_LIN);
    pot_mv = {13'h01F4, 13'h12C0};
    take();
    chk("rel full", ain[0], 11'h271);
    chk("ctr at min", ain[1], 11'h0);
    pot_mv = {13'h09C4, 13'h0960};
    take();
    chk("rel half", ain[0], 11'(code(2400) * 5000 / c5 / 8));
    chk("ctr pos", ain[1], 11'(scl(code(2500) * 5000 / 4096, 1000, 1000,
      4000)));
  endtask

  // high threshold stops channel 2, low threshold inverts it
  task automatic t_thresh();
    acfg[1] = mk(ICI_CAP_ABS, 1000, 2500, 4000, 0, ICI_CRV_LIN);
    acfg[1].hi_en = 1'b1;
    acfg[1].hi_mv = 13'h0BB8;
    acfg[1].hi_act = '{ICI_ACT_DEAD, 2'h2};
    acfg[1].lo_en = 1'b1;
    acfg[1].lo_mv = 13'h05DC;
    acfg[1].lo_act = '{ICI_ACT_INV, 2'h2};
    pot_mv[1] = 13'h0FA0;
    take();
    chk("hi stop", 11'(halt), 11'h2);
    pot_mv[1] = 13'h03E8;
    take();
    chk("lo free", 11'(halt), 11'h0);
    chk("lo inv", ocmd[1], 11'(-200));
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step(2);
    t_dead();
    t_inv();
    t_sstop();
    t_limits();
    t_estop();
    t_pulse();
    t_abs();
    t_curves();
    t_rel();
    t_thresh();
    wrap_up();
  end

  initial begin
    #20000;
    err_count++;
    wrap_up();
  end
endmodule // test_input_conditioning_actions
